// ===== src/fll_map.svh
// Register offsets, field positions, reset values and layout constants of the descriptor parser
`ifndef FLL_MAP_SVH
`define FLL_MAP_SVH

// Register byte offsets
`define FLL_OFF_CTRL 8'h00
`define FLL_OFF_STATUS 8'h04
`define FLL_OFF_FWD_ID 8'h08
`define FLL_OFF_FWD_MODE 8'h0C
`define FLL_OFF_FREQ 8'h10
`define FLL_OFF_ORBIT 8'h14
`define FLL_OFF_SYMRATE 8'h18
`define FLL_OFF_SCRAMBLE 8'h1C
`define FLL_OFF_LOGON_ID 8'h20
`define FLL_OFF_TIMEOUT 8'h24
`define FLL_OFF_RETRY 8'h28

// Control bits
`define FLL_CTRL_ENABLE 0
`define FLL_CTRL_RESTART 1
`define FLL_CTRL_RESET 32'h0000_0001

// Status bits
`define FLL_ST_FWD_VALID 0
`define FLL_ST_LOGON_VALID 1
`define FLL_ST_RESERVED 2
`define FLL_ST_SHORT 3
`define FLL_ST_REJECTED 4
`define FLL_ST_PATTERN 5
`define FLL_ST_FAILED 6
`define FLL_ST_RETRY_OK 7
`define FLL_ST_LOSS_LSB 8
`define FLL_ST_WAITING 16
`define FLL_ST_STICKY_MASK 32'h0000_003C

// Descriptor tags (assigned values are not fixed here)
`define FLL_TAG_FWD 8'hA0
`define FLL_TAG_LOGON 8'hA1

// Body lengths and codes
`define FLL_BUF_DEPTH 19
`define FLL_FWD_LEN_SHORT 8'd16
`define FLL_FWD_LEN_LONG 8'd19
`define FLL_LOGON_LEN 8'd10
`define FLL_STD0_PATTERN 3'h1
`define FLL_USAGE_RELEASE 3'h7
`define FLL_INNER_NONE 4'hF
`define FLL_INNER_MAX 4'h4

// Logon parameter reset values
`define FLL_TIMEOUT_RESET 32'h0000_FFFF
`define FLL_LOSSES_RESET 8'h03
`define FLL_RETRY_RESET 32'h0000_FFFF
`define FLL_LFSR_SEED 32'hACE1_2345

`endif

// ===== src/fll_pkg.sv
// Types shared by the descriptor parser and the logon retry timer
package fll_pkg;

  typedef enum logic [1:0] {P_TAG, P_LEN, P_BODY} parse_state_t;

  typedef enum logic [1:0] {L_IDLE, L_WAIT, L_BACKOFF, L_FAILED} logon_state_t;

  typedef struct packed {
    logic [7:0] satellite_identifier;
    logic [15:0] beam_number;
    logic [7:0] control_centre_identifier;
    logic [2:0] usage;
    logic [4:0] local_link_identifier;
    logic [31:0] frequency;
    logic [15:0] orbit;
    logic east;
    logic [1:0] polarization;
    logic [1:0] standard;
    logic scramble_default;
    logic [1:0] roll_off;
    logic [23:0] symbol_rate;
    logic [3:0] inner_code_rate;
    logic [7:0] stream_id;
    logic [2:0] spreading;
    logic [17:0] scramble_index;
  } fwd_link_t;

  typedef struct packed {
    logic [7:0] superframe_label;
    logic [31:0] response_timeout;
    logic [7:0] max_losses;
    logic [31:0] max_retry;
  } logon_param_t;

endpackage : fll_pkg

// ===== src/forward_link_logon_descriptor_parser.sv
// Forward link and logon contention descriptor parser with Avalon-MM registers
//
// Overview of operation
// - Descriptor opens with 8-bit tag then 8-bit length of the remaining bytes.
// - Forward body: satellite identifier, 16-bit beam number, control centre identifier.
// - 3-bit usage: combined, signalling, data, release; 011 to 110 reserved.
// - 5-bit link identifier; modify or release only accepted from unicast messages.
// - Carrier frequency is 32 bits unsigned in 100 Hz units.
// - Orbital position: four BCD digits, point implied after the third.
// - One orbit-half bit follows: zero west, one east.
// - 2-bit polarization: horizontal, vertical, circular left, circular right.
// - 2-bit standard: first generation, constant coding, adaptive coding, 3 reserved.
// - Standard 0 carries pattern 001; else scrambling selector and roll-off.
// - Selector 1 means scrambling index 0; selector 0 uses explicit index.
// - Roll-off: undefined, 20 %, 25 %, 35 %.
// - Symbol rate is 24 bits unsigned in 100 symbols/s units.
// - Standard 0: 4-bit inner code rate plus 4 reserved bits.
// - Standards 1, 2: stream id; selector 0 adds spreading and 18-bit index.
// - Spreading selector maps to factor and chip pattern; 111 no spreading.
// - Bytes beyond known fields up to the length are private and ignored.
// - Logon body: label, 32-bit timeout, 8-bit max losses, 32-bit retry bound.
// - Burst is lost when no response arrives within the response timeout.
// - Count consecutive losses; logon fails when count reaches max losses.
// - After a loss wait a random delay not above the retry bound.
//
// Chosen here: the register offsets and the Avalon-MM slave port.
`include "fll_map.svh"

module forward_link_logon_descriptor_parser #(
  parameter logic [7:0] FWD_TAG = `FLL_TAG_FWD,
  parameter logic [7:0] LOGON_TAG = `FLL_TAG_LOGON
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Descriptor byte stream
  input wire logic BYTE_VALID,
  input wire logic [7:0] BYTE_DATA,
  input wire logic UNICAST,
  // Logon events
  input wire logic NCR_TICK,
  input wire logic LOGON_SENT,
  input wire logic LOGON_RESPONSE,
  // Avalon-MM slave
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Results
  output logic FWD_UPDATE,
  output logic LOGON_BURST_LOST,
  output logic LOGON_FAILED,
  output logic LOGON_RETRY_OK
);

  fll_pkg::parse_state_t state;
  fll_pkg::fwd_link_t fwd;
  fll_pkg::fwd_link_t next_fwd;
  fll_pkg::logon_param_t logon;
  logic [7:0] tag;
  logic [7:0] len;
  logic [7:0] idx;
  logic [7:0] body [`FLL_BUF_DEPTH];
  logic descr_end;
  logic [31:0] ctrl;
  logic restart;
  logic fwd_valid;
  logic logon_valid;
  logic [31:0] sticky;
  logic [31:0] sticky_set;
  logic [7:0] need;
  logic fwd_ok;
  logic wr_take;
  logic rd_take;
  logic byte_in;
  logic timer_failed;
  logic timer_waiting;
  logic [7:0] timer_losses;
  logic [31:0] status;

  assign byte_in = BYTE_VALID && ctrl[`FLL_CTRL_ENABLE];
  assign wr_take = AVS_WRITE && !AVS_WAITREQUEST;
  assign rd_take = AVS_READ && AVS_WAITREQUEST;

  // Spreading selector to {factor, chips}; chip 1 is +1, 0 is -1
  function automatic logic [6:0] spread_decode(input logic [2:0] sel);
    case (sel)
      3'h0: spread_decode = {3'h2, 4'b1100};
      3'h1: spread_decode = {3'h2, 4'b1000};
      3'h2: spread_decode = {3'h3, 4'b1110};
      3'h3: spread_decode = {3'h4, 4'b1111};
      3'h4: spread_decode = {3'h4, 4'b1100};
      3'h5: spread_decode = {3'h4, 4'b1010};
      3'h6: spread_decode = {3'h4, 4'b1001};
      default: spread_decode = {3'h1, 4'b1000};
    endcase
  endfunction : spread_decode

  // Header and body framing driven by the declared length
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state <= fll_pkg::P_TAG;
      tag <= 8'h00;
      len <= 8'h00;
      idx <= 8'h00;
    end else if (byte_in) begin
      case (state)
        fll_pkg::P_TAG: begin
          tag <= BYTE_DATA;
          state <= fll_pkg::P_LEN;
        end
        fll_pkg::P_LEN: begin
          len <= BYTE_DATA;
          idx <= 8'h00;
          state <= (BYTE_DATA == 8'h00) ? fll_pkg::P_TAG : fll_pkg::P_BODY;
        end
        fll_pkg::P_BODY: begin
          idx <= idx + 8'h01;
          if (idx == len - 8'h01) begin
            state <= fll_pkg::P_TAG;
          end
        end
        default: begin
          state <= fll_pkg::P_TAG;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      descr_end <= 1'b0;
    end else begin
      descr_end <= byte_in && (((state == fll_pkg::P_LEN) && (BYTE_DATA == 8'h00)) ||
                   ((state == fll_pkg::P_BODY) && (idx == len - 8'h01)));
    end
  end

  // Body bytes held by position; bytes past the buffer are private data
  genvar gi;
  generate
    for (gi = 0; gi < `FLL_BUF_DEPTH; gi++) begin : g_body
      always_ff @(posedge CLK) begin
        if (!RESET_N) begin
          body[gi] <= 8'h00;
        end else if (byte_in && (state == fll_pkg::P_BODY) && (idx == 8'(gi))) begin
          body[gi] <= BYTE_DATA;
        end
      end
    end
  endgenerate

  // Field extraction of a forward link body
  always_comb begin
    next_fwd.satellite_identifier = body[0];
    next_fwd.beam_number = {body[1], body[2]};
    next_fwd.control_centre_identifier = body[3];
    next_fwd.usage = body[4][7:5];
    next_fwd.local_link_identifier = body[4][4:0];
    next_fwd.frequency = {body[5], body[6], body[7], body[8]};
    next_fwd.orbit = {body[9], body[10]};
    next_fwd.east = body[11][7];
    next_fwd.polarization = body[11][6:5];
    next_fwd.standard = body[11][4:3];
    next_fwd.symbol_rate = {body[12], body[13], body[14]};
    next_fwd.scramble_default = 1'b1;
    next_fwd.roll_off = 2'h0;
    next_fwd.inner_code_rate = `FLL_INNER_NONE;
    next_fwd.stream_id = 8'h00;
    next_fwd.spreading = 3'h7;
    next_fwd.scramble_index = 18'h00000;
    if (body[11][4:3] == 2'h0) begin
      next_fwd.inner_code_rate = body[15][7:4];
    end else begin
      next_fwd.scramble_default = body[11][2];
      next_fwd.roll_off = body[11][1:0];
      next_fwd.stream_id = body[15];
      if (!body[11][2]) begin
        next_fwd.spreading = body[16][7:5];
        next_fwd.scramble_index = {body[16][1:0], body[17], body[18]};
      end
    end
    need = (body[11][4:3] != 2'h0 && !body[11][2]) ? `FLL_FWD_LEN_LONG : `FLL_FWD_LEN_SHORT;
    fwd_ok = (len >= need) && (body[11][4:3] != 2'h3);
  end

  // Error and reserved-code events of a finished descriptor
  always_comb begin
    sticky_set = 32'h0000_0000;
    if (descr_end && tag == FWD_TAG) begin
      if (len < need) begin
        sticky_set[`FLL_ST_SHORT] = 1'b1;
      end
      if ((next_fwd.usage > 3'h2 && next_fwd.usage != `FLL_USAGE_RELEASE) ||
          next_fwd.standard == 2'h3 ||
          (next_fwd.standard == 2'h0 && next_fwd.inner_code_rate > `FLL_INNER_MAX &&
           next_fwd.inner_code_rate != `FLL_INNER_NONE)) begin
        sticky_set[`FLL_ST_RESERVED] = 1'b1;
      end
      if (next_fwd.standard == 2'h0 && body[11][2:0] != `FLL_STD0_PATTERN) begin
        sticky_set[`FLL_ST_PATTERN] = 1'b1;
      end
      if (fwd_ok && !UNICAST && (next_fwd.usage == `FLL_USAGE_RELEASE ||
          (fwd_valid && fwd.local_link_identifier == next_fwd.local_link_identifier))) begin
        sticky_set[`FLL_ST_REJECTED] = 1'b1;
      end
    end
    if (descr_end && tag == LOGON_TAG && len < `FLL_LOGON_LEN) begin
      sticky_set[`FLL_ST_SHORT] = 1'b1;
    end
  end

  // Forward link commit
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      fwd <= '0;
      fwd_valid <= 1'b0;
      FWD_UPDATE <= 1'b0;
    end else begin
      FWD_UPDATE <= 1'b0;
      if (descr_end && tag == FWD_TAG && fwd_ok && !sticky_set[`FLL_ST_REJECTED]) begin
        fwd <= next_fwd;
        fwd_valid <= (next_fwd.usage != `FLL_USAGE_RELEASE);
        FWD_UPDATE <= 1'b1;
      end
    end
  end

  // Logon contention commit
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      logon.superframe_label <= 8'h00;
      logon.response_timeout <= `FLL_TIMEOUT_RESET;
      logon.max_losses <= `FLL_LOSSES_RESET;
      logon.max_retry <= `FLL_RETRY_RESET;
      logon_valid <= 1'b0;
    end else if (descr_end && tag == LOGON_TAG && len >= `FLL_LOGON_LEN) begin
      logon.superframe_label <= body[0];
      logon.response_timeout <= {body[1], body[2], body[3], body[4]};
      logon.max_losses <= body[5];
      logon.max_retry <= {body[6], body[7], body[8], body[9]};
      logon_valid <= 1'b1;
    end
  end

  logon_retry_timer u_timer (
    .clk(CLK),
    .reset_n(RESET_N),
    .tick(NCR_TICK),
    .sent(LOGON_SENT),
    .response(LOGON_RESPONSE),
    .restart(restart),
    .param(logon),
    .lost(LOGON_BURST_LOST),
    .failed(timer_failed),
    .retry_ok(LOGON_RETRY_OK),
    .waiting(timer_waiting),
    .losses(timer_losses)
  );

  assign LOGON_FAILED = timer_failed;

  // Control register; restart is a self-clearing pulse
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ctrl <= `FLL_CTRL_RESET;
      restart <= 1'b0;
    end else begin
      restart <= wr_take && AVS_ADDRESS == `FLL_OFF_CTRL && AVS_BYTEENABLE[0] &&
                 AVS_WRITEDATA[`FLL_CTRL_RESTART];
      if (wr_take && AVS_ADDRESS == `FLL_OFF_CTRL && AVS_BYTEENABLE[0]) begin
        ctrl[`FLL_CTRL_ENABLE] <= AVS_WRITEDATA[`FLL_CTRL_ENABLE];
      end
    end
  end

  // Sticky flags: write one to clear, a new event wins over the clear
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      sticky <= 32'h0000_0000;
    end else if (wr_take && AVS_ADDRESS == `FLL_OFF_STATUS && AVS_BYTEENABLE[0]) begin
      sticky <= (sticky & ~(AVS_WRITEDATA & `FLL_ST_STICKY_MASK)) | sticky_set;
    end else begin
      sticky <= sticky | sticky_set;
    end
  end

  always_comb begin
    status = sticky;
    status[`FLL_ST_FWD_VALID] = fwd_valid;
    status[`FLL_ST_LOGON_VALID] = logon_valid;
    status[`FLL_ST_FAILED] = timer_failed;
    status[`FLL_ST_RETRY_OK] = LOGON_RETRY_OK;
    status[`FLL_ST_LOSS_LSB +: 8] = timer_losses;
    status[`FLL_ST_WAITING] = timer_waiting;
  end

  // Bus handshake: one wait cycle, then the answer stands for one cycle
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0000_0000;
    end else begin
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
      if (rd_take) begin
        case (AVS_ADDRESS)
          `FLL_OFF_CTRL: AVS_READDATA <= ctrl;
          `FLL_OFF_STATUS: AVS_READDATA <= status;
          `FLL_OFF_FWD_ID: AVS_READDATA <= {fwd.satellite_identifier, fwd.beam_number,
                                            fwd.control_centre_identifier};
          `FLL_OFF_FWD_MODE: AVS_READDATA <= {2'h0, spread_decode(fwd.spreading),
                                              fwd.spreading, fwd.inner_code_rate, fwd.roll_off,
                                              fwd.scramble_default, fwd.standard,
                                              fwd.polarization, fwd.east, fwd.usage,
                                              fwd.local_link_identifier};
          `FLL_OFF_FREQ: AVS_READDATA <= fwd.frequency;
          `FLL_OFF_ORBIT: AVS_READDATA <= {16'h0000, fwd.orbit};
          `FLL_OFF_SYMRATE: AVS_READDATA <= {fwd.stream_id, fwd.symbol_rate};
          `FLL_OFF_SCRAMBLE: AVS_READDATA <= {14'h0000, fwd.scramble_index};
          `FLL_OFF_LOGON_ID: AVS_READDATA <= {16'h0000, logon.max_losses,
                                              logon.superframe_label};
          `FLL_OFF_TIMEOUT: AVS_READDATA <= logon.response_timeout;
          `FLL_OFF_RETRY: AVS_READDATA <= logon.max_retry;
          default: AVS_READDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : forward_link_logon_descriptor_parser

// ===== src/logon_retry_timer.sv
// Logon burst timeout, loss counting and randomised retry delay
`include "fll_map.svh"

module logon_retry_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Events
  input wire logic tick,
  input wire logic sent,
  input wire logic response,
  input wire logic restart,
  // Parameters
  input wire fll_pkg::logon_param_t param,
  // Results
  output logic lost,
  output logic failed,
  output logic retry_ok,
  output logic waiting,
  output logic [7:0] losses
);

  fll_pkg::logon_state_t state;
  logic [31:0] count;
  logic [31:0] lfsr;
  logic [31:0] mask;
  logic [31:0] pick;
  logic [31:0] delay;

  // Free-running pseudo-random source
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lfsr <= `FLL_LFSR_SEED;
    end else begin
      lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    end
  end

  // Random value folded into 0..max_retry
  always_comb begin
    mask = param.max_retry;
    mask = mask | (mask >> 1);
    mask = mask | (mask >> 2);
    mask = mask | (mask >> 4);
    mask = mask | (mask >> 8);
    mask = mask | (mask >> 16);
    pick = lfsr & mask;
    if (pick > param.max_retry) begin
      delay = pick - param.max_retry - 32'h0000_0001;
    end else begin
      delay = pick;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= fll_pkg::L_IDLE;
      count <= 32'h0000_0000;
      losses <= 8'h00;
      lost <= 1'b0;
    end else begin
      lost <= 1'b0;
      if (restart) begin
        state <= fll_pkg::L_IDLE;
        count <= 32'h0000_0000;
        losses <= 8'h00;
      end else begin
        case (state)
          fll_pkg::L_IDLE: begin
            if (sent) begin
              state <= fll_pkg::L_WAIT;
              count <= 32'h0000_0000;
            end
          end
          fll_pkg::L_WAIT: begin
            if (response) begin
              state <= fll_pkg::L_IDLE;
              losses <= 8'h00;
            end else if (tick) begin
              if (count + 32'h0000_0001 >= param.response_timeout) begin
                lost <= 1'b1;
                losses <= losses + 8'h01;
                if (losses + 8'h01 >= param.max_losses) begin
                  state <= fll_pkg::L_FAILED;
                end else begin
                  state <= fll_pkg::L_BACKOFF;
                  count <= delay;
                end
              end else begin
                count <= count + 32'h0000_0001;
              end
            end
          end
          fll_pkg::L_BACKOFF: begin
            if (count == 32'h0000_0000) begin
              state <= fll_pkg::L_IDLE;
            end else if (tick) begin
              count <= count - 32'h0000_0001;
            end
          end
          fll_pkg::L_FAILED: begin
            state <= fll_pkg::L_FAILED;
          end
          default: begin
            state <= fll_pkg::L_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      failed <= 1'b0;
      retry_ok <= 1'b0;
      waiting <= 1'b0;
    end else begin
      failed <= (state == fll_pkg::L_FAILED);
      retry_ok <= (state == fll_pkg::L_IDLE) && !sent;
      waiting <= (state == fll_pkg::L_WAIT);
    end
  end

endmodule : logon_retry_timer

// ===== verification/fll_asserts.sv
// Port level checks of the descriptor parser
module fll_asserts (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Stream and events
  input wire logic BYTE_VALID,
  input wire logic [7:0] BYTE_DATA,
  input wire logic UNICAST,
  input wire logic NCR_TICK,
  input wire logic LOGON_SENT,
  input wire logic LOGON_RESPONSE,
  // Bus
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // Results
  input wire logic FWD_UPDATE,
  input wire logic LOGON_BURST_LOST,
  input wire logic LOGON_FAILED,
  input wire logic LOGON_RETRY_OK
);
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  a_update_one_cycle: assert property (FWD_UPDATE |=> !FWD_UPDATE)
    else $error("update pulse too long");
  a_update_after_byte: assert property (FWD_UPDATE |-> $past(BYTE_VALID, 2))
    else $error("update not two cycles after last byte");
  a_lost_after_tick: assert property (LOGON_BURST_LOST |-> $past(NCR_TICK))
    else $error("lost pulse without tick");
  a_lost_one_cycle: assert property (LOGON_BURST_LOST |=> !LOGON_BURST_LOST)
    else $error("lost pulse too long");
  a_sent_leaves_idle: assert property (LOGON_SENT && LOGON_RETRY_OK |=> !LOGON_RETRY_OK)
    else $error("retry ok after burst sent");
  a_lost_not_idle: assert property (LOGON_BURST_LOST |-> !LOGON_RETRY_OK)
    else $error("retry ok during loss");
  a_failed_not_idle: assert property (LOGON_FAILED |-> !LOGON_RETRY_OK)
    else $error("retry ok while failed");
  a_failed_on_loss: assert property (
    $rose(LOGON_FAILED) |-> LOGON_BURST_LOST || $past(LOGON_BURST_LOST))
    else $error("failed without loss");
  a_failed_held: assert property (
    $fell(LOGON_FAILED) |-> $past(AVS_WRITE) || $past(AVS_WRITE, 2) || $past(AVS_WRITE, 3))
    else $error("failed dropped without restart");

  c_update: cover property (FWD_UPDATE);
  c_lost: cover property (LOGON_BURST_LOST);
  c_failed: cover property ($rose(LOGON_FAILED));
endmodule : fll_asserts

bind forward_link_logon_descriptor_parser fll_asserts chk (.CLK(CLK), .RESET_N(RESET_N),
  .BYTE_VALID(BYTE_VALID), .BYTE_DATA(BYTE_DATA), .UNICAST(UNICAST), .NCR_TICK(NCR_TICK),
  .LOGON_SENT(LOGON_SENT), .LOGON_RESPONSE(LOGON_RESPONSE), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .FWD_UPDATE(FWD_UPDATE),
  .LOGON_BURST_LOST(LOGON_BURST_LOST), .LOGON_FAILED(LOGON_FAILED),
  .LOGON_RETRY_OK(LOGON_RETRY_OK));

// ===== verification/ncc_model.sv
// Control centre model sending descriptors as a byte stream
module ncc_model (
  // Clock
  input wire logic clk,
  // Descriptor stream
  output logic byte_valid,
  output logic [7:0] byte_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
  end

  // Idle data shows the inverse of the last byte so a stale value never looks valid
  task automatic send(input logic [7:0] tag, input logic [7:0] body[$]);
    logic [7:0] b[$];
    b = body;
    b.push_front(8'(body.size()));
    b.push_front(tag);
    foreach (b[i]) begin
      @(posedge clk);
      byte_valid <= 1'b1;
      byte_data <= b[i];
    end
    @(posedge clk);
    byte_valid <= 1'b0;
    byte_data <= ~b[b.size() - 1];
  endtask : send
endmodule : ncc_model

// ===== verification/testbench.sv
// Self-checking bench for the descriptor parser
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic unicast = 1'b1;
  logic ncr_tick = 1'b0;
  logic logon_sent = 1'b0;
  logic logon_response = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic byte_valid, avs_waitrequest, fwd_update, logon_burst_lost, logon_failed, logon_retry_ok;
  logic [7:0] byte_data;
  logic [31:0] avs_readdata, v;
  logic [7:0] d[$];
  int err_total = 0;
  int compares = 0;

  always #12.5 clk = ~clk;

  ncc_model ncc (.clk(clk), .byte_valid(byte_valid), .byte_data(byte_data));

  forward_link_logon_descriptor_parser dut (.CLK(clk), .RESET_N(rst_n),
    .BYTE_VALID(byte_valid), .BYTE_DATA(byte_data), .UNICAST(unicast), .NCR_TICK(ncr_tick),
    .LOGON_SENT(logon_sent), .LOGON_RESPONSE(logon_response), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .FWD_UPDATE(fwd_update), .LOGON_BURST_LOST(logon_burst_lost),
    .LOGON_FAILED(logon_failed), .LOGON_RETRY_OK(logon_retry_ok));

  task automatic give_verdict();
    if (err_total == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    v = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      err_total++;
      give_verdict();
    end
  endtask : bus

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(v & m, exp);
  endtask : rc

  task automatic upd(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (6) begin
      @(posedge clk);
      if (fwd_update === 1'b1) seen = 1'b1;
    end
    chk(32'(seen), 32'(exp));
  endtask : upd

  task automatic fwd(input logic [2:0] u, input logic [1:0] s, input logic [2:0] lo,
    input logic [7:0] b15, input logic [2:0] sp, input int len);
    d = '{8'h11, 8'h22, 8'h33, 8'h44, {u, 5'h0A}, 8'h12, 8'h34, 8'h56, 8'h78, 8'h01, 8'h92,
      {1'b1, 2'b10, s, lo}, 8'h01, 8'h23, 8'h45, b15, {sp, 5'h02}, 8'h00, 8'h05};
    while (d.size() > len) d.pop_back();
    while (d.size() < len) d.push_back(8'hEE);
    ncc.send(8'hA0, d);
  endtask : fwd

  // Ticks every fifth cycle, counting ticks until lost (sel 0) or retry ok (sel 1)
  task automatic ticks(input logic sel, output int n);
    logic hit;
    hit = 1'b0;
    n = 0;
    while (!hit && n < 40) begin
      @(posedge clk);
      ncr_tick <= 1'b1;
      n++;
      @(posedge clk);
      ncr_tick <= 1'b0;
      repeat (3) begin
        @(posedge clk);
        if ((sel ? logon_retry_ok : logon_burst_lost) === 1'b1) hit = 1'b1;
      end
    end
    if (!hit) begin
      err_total++;
      give_verdict();
    end
  endtask : ticks

  task automatic pulse(input logic rsp);
    @(posedge clk);
    logon_sent <= !rsp;
    logon_response <= rsp;
    @(posedge clk);
    logon_sent <= 1'b0;
    logon_response <= 1'b0;
  endtask : pulse

  task automatic run_reset_values();
    rc(8'h00, 32'h1, 32'h1);
    rc(8'h20, 32'hFF00, 32'h300);
    rc(8'h24, 32'hFFFFFFFF, 32'hFFFF);
    rc(8'h28, 32'hFFFFFFFF, 32'hFFFF);
    bus(1'b1, 8'h3C, 32'hFFFFFFFF);
    rc(8'h3C, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, 8'h10, 32'hFFFFFFFF);
    rc(8'h10, 32'hFFFFFFFF, 32'h0);
  endtask : run_reset_values

  task automatic run_std0();
    fwd(3'h0, 2'h0, 3'h1, 8'h2F, 3'h0, 17);
    upd(1'b1);
    rc(8'h08, 32'hFFFFFFFF, 32'h11223344);
    rc(8'h10, 32'hFFFFFFFF, 32'h12345678);
    rc(8'h14, 32'hFFFF, 32'h192);
    rc(8'h18, 32'hFFFFFF, 32'h12345);
    rc(8'h0C, 32'h7FFFFF, 32'h72250A);
    rc(8'h1C, 32'hFFFFFFFF, 32'h0);
  endtask : run_std0

  task automatic run_std12();
    logic [3:0] pat[8];
    logic [2:0] fac, u;
    logic [1:0] s;
    logic [31:0] e;
    pat = '{4'hC, 4'h8, 4'hE, 4'hF, 4'hC, 4'hA, 4'h9, 4'h8};
    for (int i = 0; i < 8; i++) begin
      u = (i < 3) ? 3'(i) : 3'h7;
      s = 2'(1 + i % 2);
      fac = (i < 2) ? 3'h2 : (i == 2) ? 3'h3 : (i == 7) ? 3'h1 : 3'h4;
      e = {2'h0, fac, pat[i], 3'(i), 4'h0, 2'(i), 1'b0, s, 2'h2, 1'b1, u, 5'h0A};
      fwd(u, s, {1'b0, 2'(i)}, 8'h3C, 3'(i), 19);
      upd(1'b1);
      rc(8'h0C, 32'h3FF0FFFF, e);
      rc(8'h18, 32'hFFFFFFFF, 32'h3C012345);
      rc(8'h1C, 32'hFFFFFFFF, 32'h20005);
    end
  endtask : run_std12

  task automatic run_refusals();
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 8'h04, 32'h3C);
      fwd((i == 0) ? 3'h4 : 3'h0, (i == 2) ? 2'h3 : 2'h0, 3'h1, (i == 1) ? 8'h5F : 8'h2F,
        3'h0, 16);
      repeat (6) @(posedge clk);
      rc(8'h04, 32'h4, 32'h4);
    end
    fwd(3'h0, 2'h3, 3'h1, 8'h2F, 3'h0, 16);
    upd(1'b0);
    fwd(3'h0, 2'h0, 3'h1, 8'h2F, 3'h0, 10);
    upd(1'b0);
    rc(8'h04, 32'h8, 32'h8);
    fwd(3'h0, 2'h0, 3'h3, 8'h2F, 3'h0, 16);
    repeat (6) @(posedge clk);
    rc(8'h04, 32'h20, 32'h20);
    d = '{8'hA0, 8'h10, 8'h03};
    ncc.send(8'h55, d);
    fwd(3'h1, 2'h0, 3'h1, 8'h2F, 3'h0, 16);
    upd(1'b1);
    bus(1'b1, 8'h04, 32'h3C);
    unicast <= 1'b0;
    fwd(3'h7, 2'h0, 3'h1, 8'h2F, 3'h0, 16);
    upd(1'b0);
    rc(8'h04, 32'h10, 32'h10);
    fwd(3'h1, 2'h0, 3'h1, 8'h2F, 3'h0, 16);
    upd(1'b0);
    unicast <= 1'b1;
  endtask : run_refusals

  task automatic run_logon();
    int n;
    d = '{8'h5A, 8'h00, 8'h00, 8'h00, 8'h03, 8'h02, 8'h00, 8'h00, 8'h00, 8'h04};
    ncc.send(8'hA1, d);
    repeat (4) @(posedge clk);
    rc(8'h20, 32'hFFFF, 32'h25A);
    rc(8'h24, 32'hFFFFFFFF, 32'h3);
    rc(8'h28, 32'hFFFFFFFF, 32'h4);
    for (int k = 0; k < 2; k++) begin
      ticks(1'b1, n);
      chk(32'(n <= 4), 32'h1);
      pulse(1'b0);
      ticks(1'b0, n);
      chk(32'(n), 32'h3);
      rc(8'h04, 32'hFF40, {16'h0, 8'(k + 1), 1'b0, 1'(k), 6'h0});
    end
    chk(32'(logon_failed), 32'h1);
    bus(1'b1, 8'h00, 32'h3);
    repeat (4) @(posedge clk);
    chk(32'(logon_failed), 32'h0);
    ticks(1'b1, n);
    pulse(1'b0);
    ticks(1'b0, n);
    ticks(1'b1, n);
    pulse(1'b0);
    repeat (3) @(posedge clk);
    pulse(1'b1);
    repeat (3) @(posedge clk);
    chk(32'(logon_retry_ok), 32'h1);
    rc(8'h04, 32'h1FF00, 32'h0);
  endtask : run_logon

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    run_reset_values();
    run_std0();
    run_std12();
    run_refusals();
    run_logon();
    give_verdict();
  end
endmodule : testbench
